/* File: dv/mcuirq_core_model.sv */
// core model: program counter and return stack
module mcuirq_core_model
	import mcuirq_pkg::*;
#(parameter int DEPTH = 2)
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic slow,
	input wire logic irq_call,
	input wire logic [PC_W-1:0] irq_vector,
	input wire logic [PC_W-1:0] push_pc,
	input wire logic pop,
	output logic core_ready,
	output logic stack_full,
	output logic [PC_W-1:0] next_pc
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [PC_W-1:0] stk [DEPTH];
	logic tog;
	int sp;
	assign stack_full = (sp == DEPTH);
	assign core_ready = !slow || tog;
	always @(posedge clk) begin
		tog <= !tog && rst_b;
		if (!rst_b) begin
			sp <= 0;
			next_pc <= 12'h100;
		end else if (irq_call) begin
			stk[sp] <= push_pc;
			sp <= sp + 1;
			next_pc <= irq_vector;
		end else if (pop && sp > 0) begin
			sp <= sp - 1;
			next_pc <= stk[sp-1];
		end
	end
endmodule

/* File: dv/testbench.sv */
// self-checking bench for the interrupt unit
module testbench
	import mcuirq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_b, osc, ovf, rti, ret, slp, iw, tw, slow, rdy, full;
	logic call, wake, divclk;
	logic [7:0] wd, interrupt_control, time_base_control, r;
	logic [PC_W-1:0] npc, vec, ppc;
	logic [23:0] exp_q [$];
	int num_errors, num_checks, wakes, divs, i;
	mcuirq_unit u_dut (.clk(clk), .rst_b(rst_b), .low_speed_osc_clock(osc), .counter_overflow(ovf),
		.core_ready(rdy), .stack_full(full), .return_from_irq(rti), .plain_return(ret), .sleep_mode(slp),
		.next_pc(npc), .interrupt_control_wr(iw), .tbc_wr(tw), .reg_wdata(wd), .interrupt_control_rdata(interrupt_control), .tbc_rdata(time_base_control),
		.irq_call(call), .irq_vector(vec), .push_pc(ppc), .wake_up(wake), .tick_divider_clock(divclk));
	mcuirq_core_model u_core (.clk(clk), .rst_b(rst_b), .slow(slow), .irq_call(call), .irq_vector(vec),
		.push_pc(ppc), .pop(rti | ret), .core_ready(rdy), .stack_full(full), .next_pc(npc));
	always #25 clk = ~clk;
	task automatic cyc(int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic chk(logic [31:0] got, logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(bit t, logic [7:0] d);
		iw = !t;
		tw = t;
		wd = d;
		cyc(1);
		iw = 0;
		tw = 0;
	endtask
	task automatic pulse_ovf;
		ovf = 1;
		cyc(1);
		ovf = 0;
		cyc(3);
	endtask
	task automatic tb_run(int n);
		for (i = 1; i <= n + 50; i++) begin
			osc = 1;
			cyc(2);
			osc = 0;
			cyc(3);
			if (interrupt_control[5] === 1'b1) break;
		end
		if (i > n + 50) begin
			num_errors++;
			final_report();
		end else begin
			chk(i, n);
		end
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	always @(negedge clk) begin
		if (call === 1'b1) begin
			if (exp_q.size() == 0) chk(1, 0);
			else chk({vec, ppc}, exp_q.pop_front());
		end
		if (wake === 1'b1) wakes++;
		if (divclk === 1'b1) divs++;
	end
	initial begin
		{rst_b, osc, ovf, rti, ret, slp, iw, tw, wd} = '0;
		void'($urandom(32559));
		slow = 1'($urandom % 2);
		r = 8'($urandom);
		cyc(10);
		rst_b = 1;
		cyc(1);
		chk(interrupt_control, 8'h00);
		chk(time_base_control, 8'h00);
		wr(1, r & 8'h7f);
		chk(time_base_control, r & 8'h07);
		wr(0, r & 8'hfe);
		chk(interrupt_control, r & 8'h36);
		wr(0, 8'h00);
		pulse_ovf();
		chk(interrupt_control, 8'h10);
		wr(0, 8'h11);
		cyc(3);
		chk(interrupt_control, 8'h11);
		$display("test flags done");
		exp_q.push_back({VEC_CNT, 12'h100});
		wr(0, 8'h13);
		cyc(3);
		chk(interrupt_control, 8'h02);
		pulse_ovf();
		chk(interrupt_control, 8'h12);
		exp_q.push_back({VEC_CNT, VEC_CNT});
		wr(0, 8'h13);
		cyc(3);
		chk(interrupt_control, 8'h02);
		ovf = 1;
		cyc(1);
		ovf = 0;
		wr(0, 8'h13);
		cyc(4);
		chk(interrupt_control, 8'h13);
		exp_q.push_back({VEC_CNT, VEC_CNT});
		rti = 1;
		cyc(1);
		rti = 0;
		cyc(4);
		chk(interrupt_control, 8'h02);
		repeat (2) begin
			ret = 1;
			cyc(1);
			ret = 0;
			cyc(2);
		end
		chk(interrupt_control, 8'h02);
		rti = 1;
		cyc(1);
		rti = 0;
		cyc(2);
		chk(interrupt_control, 8'h03);
		$display("test call and stack done");
		wr(0, 8'h06);
		wr(1, 8'h80);
		divs = 0;
		tb_run(2048);
		chk(divs, 16);
		pulse_ovf();
		chk(interrupt_control, 8'h36);
		wr(1, 8'h00);
		exp_q.push_back({VEC_CNT, 12'h100});
		exp_q.push_back({VEC_TICK, 12'h100});
		wr(0, 8'h37);
		cyc(4);
		chk(interrupt_control, 8'h26);
		rti = 1;
		cyc(1);
		rti = 0;
		cyc(4);
		chk(interrupt_control, 8'h06);
		wr(0, 8'h00);
		wr(1, 8'h81);
		tb_run(4096);
		chk(interrupt_control, 8'h20);
		wr(1, 8'h00);
		wr(0, 8'h00);
		$display("test time base done");
		slp = 1;
		pulse_ovf();
		chk(wakes, 1);
		pulse_ovf();
		chk(wakes, 1);
		slp = 0;
		$display("test wake done");
		chk(exp_q.size(), 0);
		final_report();
	end
endmodule

/* File: hw/mcuirq_pkg.sv */
// constants for the interrupt unit and its time base
package mcuirq_pkg;
	localparam int PC_W = 12;
	localparam int NSRC = 2;
	localparam int SRC_CNT = 0;
	localparam int SRC_TICK = 1;
	// interrupt_control field positions
	localparam int GIE_BIT = 0;
	localparam int EN_BIT [NSRC] = '{1, 2};
	localparam int FLAG_BIT [NSRC] = '{4, 5};
	localparam logic [7:0] INTERRUPT_CONTROL_RST = 8'h00;
	// time_base_control field positions
	localparam int TICK_ENABLE_BIT = 7;
	localparam int PSEL_LSB = 0;
	localparam int PSEL_W = 3;
	localparam logic [7:0] TBC_RST = 8'h00;
	// time base chain
	localparam int PSC_W = 7;
	localparam logic [PSC_W-1:0] PSC_LAST = 7'h7f;
	localparam int DIV_W = 11;
	localparam int DIV_BASE = 4;
	localparam logic [DIV_W-1:0] DIV_ONES = 11'h7ff;
	// vector addresses
	localparam logic [PC_W-1:0] VEC_CNT = 12'h008;
	localparam logic [PC_W-1:0] VEC_TICK = 12'h00c;
endpackage

/* File: hw/mcuirq_unit.sv */
// interrupt unit with time base divider
// Notes on behaviour
// - source event sets its request flag
// - disabled source keeps flag, never vectors
// - global enable low suppresses every interrupt
// - entry pushes next pc, loads vector
// - each source has its own vector
// - servicing clears global enable, no nesting
// - requests while blocked still set flags
// - full stack blocks acknowledge of requests
// - flag rising edge wakes from sleep/idle
// - time base overflow sets tick flag
// - tick service clears tick flag
// - counter overflow sets counter flag
// - counter service clears counter flag
// - divider input is slow oscillator over 128
// - period select gives 2^(4+code) input clocks
// - time_base_control bit7 enables, resets zero
// - interrupt_control bit map, all reset zero
// - unimplemented control bits read zero
// - flag holds until serviced or cleared
// - return_from_irq pops and sets global enable
// - plain return leaves global enable unchanged
// - only program counter saved on entry
module mcuirq_unit
	import mcuirq_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic low_speed_osc_clock,
	input wire logic counter_overflow,
	input wire logic core_ready,
	input wire logic stack_full,
	input wire logic return_from_irq,
	input wire logic plain_return,
	input wire logic sleep_mode,
	input wire logic [PC_W-1:0] next_pc,
	input wire logic interrupt_control_wr,
	input wire logic tbc_wr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] interrupt_control_rdata,
	output logic [7:0] tbc_rdata,
	output logic irq_call,
	output logic [PC_W-1:0] irq_vector,
	output logic [PC_W-1:0] push_pc,
	output logic wake_up,
	output logic tick_divider_clock
);
	logic [NSRC-1:0] flag_reg, flag_next;
	logic [NSRC-1:0] en_reg, en_next;
	logic gie_reg, gie_next;
	logic tick_enable_reg, tick_enable_next;
	logic [PSEL_W-1:0] psel_reg, psel_next;
	logic osc_d_reg, osc_d_next;
	logic [PSC_W-1:0] psc_reg, psc_next;
	logic [DIV_W-1:0] div_reg, div_next;
	logic [DIV_W-1:0] div_mask;
	logic osc_rise, psc_pulse, tick_evt;
	logic [NSRC-1:0] src_evt, pend, grant;
	logic take;
	logic [PC_W-1:0] vec_sel;
	logic [7:0] interrupt_control_rdata_reg, interrupt_control_rdata_next;
	logic [7:0] tbc_rdata_reg, tbc_rdata_next;
	logic irq_call_reg, irq_call_next;
	logic [PC_W-1:0] irq_vector_reg, irq_vector_next;
	logic [PC_W-1:0] push_pc_reg, push_pc_next;
	logic wake_up_reg, wake_up_next;
	logic tdc_reg, tdc_next;

	// time base chain
	always_comb begin
		osc_d_next = low_speed_osc_clock;
		osc_rise = low_speed_osc_clock & ~osc_d_reg;
		tick_enable_next = tick_enable_reg;
		psel_next = psel_reg;
		if (tbc_wr) begin
			tick_enable_next = reg_wdata[TICK_ENABLE_BIT];
			psel_next = reg_wdata[PSEL_LSB +: PSEL_W];
		end
		psc_next = psc_reg;
		div_next = div_reg;
		psc_pulse = 1'b0;
		div_mask = ~(DIV_ONES << (DIV_BASE + int'(psel_reg))) & DIV_ONES;
		tick_evt = 1'b0;
		if (!tick_enable_reg) begin
			psc_next = '0;
			div_next = '0;
		end else if (osc_rise) begin
			psc_next = psc_reg + 1'b1;
			psc_pulse = (psc_reg == PSC_LAST);
			if (psc_pulse) begin
				div_next = div_reg + 1'b1;
				tick_evt = ((div_reg & div_mask) == div_mask);
			end
		end
		tdc_next = psc_pulse;
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			tick_enable_reg <= TBC_RST[TICK_ENABLE_BIT];
			psel_reg <= TBC_RST[PSEL_LSB +: PSEL_W];
			osc_d_reg <= 1'b0;
			psc_reg <= '0;
			div_reg <= '0;
			tdc_reg <= 1'b0;
		end else begin
			tick_enable_reg <= tick_enable_next;
			psel_reg <= psel_next;
			osc_d_reg <= osc_d_next;
			psc_reg <= psc_next;
			div_reg <= div_next;
			tdc_reg <= tdc_next;
		end
	end

	// arbitration and call request
	always_comb begin
		src_evt[SRC_CNT] = counter_overflow;
		src_evt[SRC_TICK] = tick_evt;
		pend = flag_reg & en_reg;
		grant = '0;
		if (pend[SRC_CNT]) begin
			grant[SRC_CNT] = 1'b1;
		end else if (pend[SRC_TICK]) begin
			grant[SRC_TICK] = 1'b1;
		end
		take = gie_reg & core_ready & ~stack_full & (|pend);
		vec_sel = grant[SRC_CNT] ? VEC_CNT : VEC_TICK;
		gie_next = gie_reg;
		if (interrupt_control_wr) begin
			gie_next = reg_wdata[GIE_BIT];
		end
		if (return_from_irq) begin
			gie_next = 1'b1;
		end
		if (take) begin
			gie_next = 1'b0;
		end
		irq_call_next = take;
		irq_vector_next = take ? vec_sel : irq_vector_reg;
		push_pc_next = take ? next_pc : push_pc_reg;
	end

	// per source request flags and enables
	genvar gi;
	generate
		for (gi = 0; gi < NSRC; gi++) begin : g_src
			always_comb begin
				en_next[gi] = interrupt_control_wr ? reg_wdata[EN_BIT[gi]] : en_reg[gi];
				flag_next[gi] = flag_reg[gi];
				if (interrupt_control_wr) begin
					flag_next[gi] = reg_wdata[FLAG_BIT[gi]];
				end
				if (take && grant[gi]) begin
					flag_next[gi] = 1'b0;
				end
				if (src_evt[gi]) begin
					flag_next[gi] = 1'b1;
				end
			end
		end
	endgenerate

	// register readback and wake
	always_comb begin
		interrupt_control_rdata_next = 8'h00;
		interrupt_control_rdata_next[GIE_BIT] = gie_next;
		tbc_rdata_next = 8'h00;
		tbc_rdata_next[TICK_ENABLE_BIT] = tick_enable_next;
		tbc_rdata_next[PSEL_LSB +: PSEL_W] = psel_next;
		for (int i = 0; i < NSRC; i++) begin
			interrupt_control_rdata_next[EN_BIT[i]] = en_next[i];
			interrupt_control_rdata_next[FLAG_BIT[i]] = flag_next[i];
		end
		wake_up_next = sleep_mode & (|(flag_next & ~flag_reg));
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			flag_reg <= '0;
			en_reg <= '0;
			gie_reg <= INTERRUPT_CONTROL_RST[GIE_BIT];
			interrupt_control_rdata_reg <= INTERRUPT_CONTROL_RST;
			tbc_rdata_reg <= TBC_RST;
			irq_call_reg <= 1'b0;
			irq_vector_reg <= '0;
			push_pc_reg <= '0;
			wake_up_reg <= 1'b0;
		end else begin
			flag_reg <= flag_next;
			en_reg <= en_next;
			gie_reg <= gie_next;
			interrupt_control_rdata_reg <= interrupt_control_rdata_next;
			tbc_rdata_reg <= tbc_rdata_next;
			irq_call_reg <= irq_call_next;
			irq_vector_reg <= irq_vector_next;
			push_pc_reg <= push_pc_next;
			wake_up_reg <= wake_up_next;
		end
	end

	assign interrupt_control_rdata = interrupt_control_rdata_reg;
	assign tbc_rdata = tbc_rdata_reg;
	assign irq_call = irq_call_reg;
	assign irq_vector = irq_vector_reg;
	assign push_pc = push_pc_reg;
	assign wake_up = wake_up_reg;
	assign tick_divider_clock = tdc_reg;

	// checks
	property p_cnt_set;
		@(posedge clk) disable iff (!rst_b)
		counter_overflow |=> flag_reg[SRC_CNT] && interrupt_control_rdata[FLAG_BIT[SRC_CNT]];
	endproperty
	a_cnt_set: assert property (p_cnt_set) else $error("counter flag not set");

	property p_tick_set;
		@(posedge clk) disable iff (!rst_b)
		tick_evt |=> flag_reg[SRC_TICK];
	endproperty
	a_tick_set: assert property (p_tick_set) else $error("tick flag not set");

	property p_masked;
		@(posedge clk) disable iff (!rst_b)
		(en_reg == '0) |=> !irq_call;
	endproperty
	a_masked: assert property (p_masked) else $error("call with sources disabled");

	property p_global_off;
		@(posedge clk) disable iff (!rst_b)
		!gie_reg |=> !irq_call;
	endproperty
	a_global_off: assert property (p_global_off) else $error("call with global enable low");

	property p_entry;
		@(posedge clk) disable iff (!rst_b)
		take |=> irq_call && push_pc == $past(next_pc) ##1 !irq_call;
	endproperty
	a_entry: assert property (p_entry) else $error("entry push or pulse wrong");

	property p_prio;
		@(posedge clk) disable iff (!rst_b)
		irq_call && $past(pend[SRC_CNT]) |-> irq_vector == VEC_CNT;
	endproperty
	a_prio: assert property (p_prio) else $error("counter not preferred");

	property p_vec_tick;
		@(posedge clk) disable iff (!rst_b)
		irq_call && !$past(pend[SRC_CNT]) |-> irq_vector == VEC_TICK;
	endproperty
	a_vec_tick: assert property (p_vec_tick) else $error("tick vector wrong");

	property p_no_nest;
		@(posedge clk) disable iff (!rst_b)
		irq_call |-> !gie_reg && !interrupt_control_rdata[GIE_BIT];
	endproperty
	a_no_nest: assert property (p_no_nest) else $error("global enable kept on entry");

	property p_stack_full;
		@(posedge clk) disable iff (!rst_b)
		stack_full |=> !irq_call;
	endproperty
	a_stack_full: assert property (p_stack_full) else $error("call with full stack");

	property p_wake;
		@(posedge clk) disable iff (!rst_b)
		sleep_mode && counter_overflow && !flag_reg[SRC_CNT] |=> wake_up;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake on flag rise");

	property p_cnt_clear;
		@(posedge clk) disable iff (!rst_b)
		take && grant[SRC_CNT] && !counter_overflow |=> !flag_reg[SRC_CNT];
	endproperty
	a_cnt_clear: assert property (p_cnt_clear) else $error("counter flag not cleared");

	property p_hold;
		@(posedge clk) disable iff (!rst_b)
		flag_reg[SRC_TICK] && !interrupt_control_wr && !(take && grant[SRC_TICK]) |=> flag_reg[SRC_TICK];
	endproperty
	a_hold: assert property (p_hold) else $error("flag dropped");

	property p_return_from_irq;
		@(posedge clk) disable iff (!rst_b)
		return_from_irq && !take |=> gie_reg;
	endproperty
	a_return_from_irq: assert property (p_return_from_irq) else $error("global enable not set by return");

	property p_ret;
		@(posedge clk) disable iff (!rst_b)
		plain_return && !return_from_irq && !interrupt_control_wr && !take |=> gie_reg == $past(gie_reg);
	endproperty
	a_ret: assert property (p_ret) else $error("plain return changed global enable");

	property p_zero_bits;
		@(posedge clk) disable iff (!rst_b)
		interrupt_control_rdata[7:6] == 2'h0 && !interrupt_control_rdata[3] && tbc_rdata[6:3] == 4'h0;
	endproperty
	a_zero_bits: assert property (p_zero_bits) else $error("unimplemented bit nonzero");
endmodule
